// file: ipsel_pkg.sv
/*
  Package of the interrupt priority selector: register indices and byte
  addresses, field positions, reset values, source numbering and the
  request carrier toward the CPU.
  Assumes a 32-bit Avalon-MM slave with byte addressing.
*/
package ipsel_pkg;

  localparam int ADDR_W = 18;
  localparam int NSRC   = 18;
  localparam int SRC_W  = 5;

  // Printed offsets are not word multiples, so each is a word index
  localparam logic [15:0] IDX_SYS_CTRL = 16'hfff2;
  localparam logic [15:0] IDX_PRIO_A   = 16'hfff8;
  localparam logic [15:0] IDX_PRIO_B   = 16'hfff9;
  localparam logic [15:0] IDX_STATUS   = 16'hfffa;
  localparam logic [ADDR_W-1:0] ADR_SYS_CTRL = {IDX_SYS_CTRL, 2'b00};
  localparam logic [ADDR_W-1:0] ADR_PRIO_A   = {IDX_PRIO_A, 2'b00};
  localparam logic [ADDR_W-1:0] ADR_PRIO_B   = {IDX_PRIO_B, 2'b00};
  localparam logic [ADDR_W-1:0] ADR_STATUS   = {IDX_STATUS, 2'b00};

  localparam logic [7:0] RST_SYS_CTRL = 8'h00;
  localparam logic [7:0] RST_PRIO_A   = 8'h00;
  localparam logic [7:0] RST_PRIO_B   = 8'h00;

  localparam int SC_NMI_EDGE = 2;
  localparam int PA_EXT0     = 7;
  localparam int PA_EXT1     = 6;
  localparam int PA_EXT2_3   = 5;
  localparam int PA_EXT4_5   = 4;
  localparam int PA_WDT_REF  = 3;
  localparam int PA_TMR0     = 2;
  localparam int PA_TMR1     = 1;
  localparam int PA_TMR2     = 0;
  localparam int PB_TMR3     = 7;
  localparam int PB_TMR4     = 6;
  localparam int PB_DMA      = 5;
  localparam int PB_SER0     = 3;
  localparam int PB_SER1     = 2;
  localparam int PB_ADC      = 1;
  localparam logic [7:0] PB_LIVE_MASK = 8'hee;

  localparam int ST_NMI   = 7;
  localparam int ST_VALID = 6;
  localparam int ST_LEVEL = 5;

  // Lower number wins among equal levels
  typedef enum logic [SRC_W-1:0] {
    SRC_EXT0 = 5'h00, SRC_EXT1 = 5'h01, SRC_EXT2 = 5'h02,
    SRC_EXT3 = 5'h03, SRC_EXT4 = 5'h04, SRC_EXT5 = 5'h05,
    SRC_WDT  = 5'h06, SRC_REF  = 5'h07, SRC_TMR0 = 5'h08,
    SRC_TMR1 = 5'h09, SRC_TMR2 = 5'h0a, SRC_TMR3 = 5'h0b,
    SRC_TMR4 = 5'h0c, SRC_DMA0 = 5'h0d, SRC_DMA1 = 5'h0e,
    SRC_SER0 = 5'h0f, SRC_SER1 = 5'h10, SRC_ADC  = 5'h11
  } ipsel_src_t;

  typedef struct packed {
    logic             valid;
    logic             level;
    logic [SRC_W-1:0] source;
  } ipsel_req_t;

  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic              read;
    logic              write;
    logic [31:0]       writedata;
    logic [3:0]        byteenable;
  } ipsel_bus_t;

endpackage

// file: ipsel_reg8.sv
/*
  One 8-bit software register with byte-lane write and a level clear.
  Assumes the write strobe is a single-cycle pulse from the bus slave.
*/
`timescale 1ns/1ps
module ipsel_reg8 #(
  parameter logic [7:0] RST = 8'h00
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       clr,
  input  wire logic       we,
  input  wire logic [7:0] wdata,
  output logic      [7:0] q
);

  // Clear beats a write, so standby cannot be undone by software
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= RST;
    end else if (clr) begin
      q <= RST;
    end else if (we) begin
      q <= wdata;
    end
  end

endmodule

// file: ipsel_pick.sv
/*
  Fixed-order pick: lowest-numbered asserted request wins.
  Purely combinational; the caller registers the outcome.
*/
`timescale 1ns/1ps
module ipsel_pick #(
  parameter int N = 18,
  parameter int W = 5
) (
  input  wire logic [N-1:0] req,
  output logic              found,
  output logic      [W-1:0] idx
);

  always_comb begin
    found = 1'b0;
    idx   = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        found = 1'b1;
        idx   = W'(i);
      end
    end
  end

endmodule

// file: ipsel_top.sv
/*
  Interrupt priority selector: two priority registers, the nonmaskable
  edge select, nonmaskable edge capture and a two-level fixed-order
  arbiter presenting one request to the CPU.
  Assumes source requests and the nonmaskable input are synchronous to
  clk and that a source holds its request until the CPU serves it.
*/
`timescale 1ns/1ps
module ipsel_top (
  input  wire logic                        clk,
  input  wire logic                        arst_n,
  input  wire logic                        hwStandby,
  input  wire logic [ipsel_pkg::ADDR_W-1:0] address,
  input  wire logic                        read,
  input  wire logic                        write,
  input  wire logic [31:0]                 writedata,
  input  wire logic [3:0]                  byteenable,
  output logic      [31:0]                 readdata,
  output logic                             waitrequest,
  input  wire logic                        nmiIn,
  input  wire logic                        nmiAck,
  input  wire logic [ipsel_pkg::NSRC-1:0]  srcReq,
  output logic                             nmiPending,
  output ipsel_pkg::ipsel_req_t            intReq
);
  import ipsel_pkg::*;

  ipsel_bus_t       bus;
  logic             ackQ_q;
  logic             wrStrobe;
  logic [7:0]       sysCtrl_q;
  logic [7:0]       prioA_q;
  logic [7:0]       prioB_q;
  logic [7:0]       statusVal;
  logic [7:0]       rdByte;
  logic [31:0]      readdata_q;
  logic             nmiPrev_q;
  logic             nmiEdge;
  logic             nmiPending_q;
  logic [NSRC-1:0]  levelVec;
  logic [NSRC-1:0]  hiReq;
  logic [NSRC-1:0]  loReq;
  logic             hiFound;
  logic             loFound;
  logic [SRC_W-1:0] hiIdx;
  logic [SRC_W-1:0] loIdx;
  ipsel_req_t       intReq_d;
  ipsel_req_t       intReq_q;

  assign bus = '{address: address, read: read, write: write,
                 writedata: writedata, byteenable: byteenable};

  // Every access takes two cycles; read data then come from a flop
  assign waitrequest = (bus.read || bus.write) && !ackQ_q;
  assign wrStrobe    = bus.write && ackQ_q && bus.byteenable[0];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ackQ_q <= 1'b0;
    end else begin
      ackQ_q <= (bus.read || bus.write) && !ackQ_q;
    end
  end

  ipsel_reg8 #(.RST(RST_SYS_CTRL)) uSysCtrl (
    .clk   (clk),
    .arst_n(arst_n),
    .clr   (hwStandby),
    .we    (wrStrobe && bus.address == ADR_SYS_CTRL),
    .wdata (bus.writedata[7:0] & (8'h01 << SC_NMI_EDGE)),
    .q     (sysCtrl_q)
  );

  ipsel_reg8 #(.RST(RST_PRIO_A)) uPrioA (
    .clk   (clk),
    .arst_n(arst_n),
    .clr   (hwStandby),
    .we    (wrStrobe && bus.address == ADR_PRIO_A),
    .wdata (bus.writedata[7:0]),
    .q     (prioA_q)
  );

  ipsel_reg8 #(.RST(RST_PRIO_B)) uPrioB (
    .clk   (clk),
    .arst_n(arst_n),
    .clr   (hwStandby),
    .we    (wrStrobe && bus.address == ADR_PRIO_B),
    .wdata (bus.writedata[7:0]),
    .q     (prioB_q)
  );

  assign statusVal = {nmiPending_q, intReq_q.valid, intReq_q.level,
                      intReq_q.source};

  always_comb begin
    case (bus.address)
      ADR_SYS_CTRL: rdByte = sysCtrl_q;
      ADR_PRIO_A:   rdByte = prioA_q;
      ADR_PRIO_B:   rdByte = prioB_q;
      ADR_STATUS:   rdByte = statusVal;
      default:      rdByte = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      readdata_q <= 32'h0000_0000;
    end else if (bus.read && !ackQ_q) begin
      readdata_q <= {24'h00_0000, rdByte};
    end
  end
  assign readdata = readdata_q;

  // Changing the edge select alone never looks like an edge; both tests need nmiIn to differ from nmiPrev_q
  always_comb begin
    if (sysCtrl_q[SC_NMI_EDGE]) begin
      nmiEdge = !nmiPrev_q && nmiIn;
    end else begin
      nmiEdge = nmiPrev_q && !nmiIn;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      nmiPrev_q <= 1'b1;
    end else begin
      nmiPrev_q <= nmiIn;
    end
  end

  // A new edge in the acknowledge cycle is kept: set beats clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      nmiPending_q <= 1'b0;
    end else if (hwStandby) begin
      nmiPending_q <= 1'b0;
    end else if (nmiEdge) begin
      nmiPending_q <= 1'b1;
    end else if (nmiAck) begin
      nmiPending_q <= 1'b0;
    end
  end
  assign nmiPending = nmiPending_q;

  // Level 1 is high, level 0 low
  always_comb begin
    levelVec                = '0;
    levelVec[SRC_EXT0]      = prioA_q[PA_EXT0];
    levelVec[SRC_EXT1]      = prioA_q[PA_EXT1];
    levelVec[SRC_EXT2]      = prioA_q[PA_EXT2_3];
    levelVec[SRC_EXT3]      = prioA_q[PA_EXT2_3];
    levelVec[SRC_EXT4]      = prioA_q[PA_EXT4_5];
    levelVec[SRC_EXT5]      = prioA_q[PA_EXT4_5];
    levelVec[SRC_WDT]       = prioA_q[PA_WDT_REF];
    levelVec[SRC_REF]       = prioA_q[PA_WDT_REF];
    levelVec[SRC_TMR0]      = prioA_q[PA_TMR0];
    levelVec[SRC_TMR1]      = prioA_q[PA_TMR1];
    levelVec[SRC_TMR2]      = prioA_q[PA_TMR2];
    levelVec[SRC_TMR3]      = prioB_q[PB_TMR3];
    levelVec[SRC_TMR4]      = prioB_q[PB_TMR4];
    levelVec[SRC_DMA0]      = prioB_q[PB_DMA];
    levelVec[SRC_DMA1]      = prioB_q[PB_DMA];
    levelVec[SRC_SER0]      = prioB_q[PB_SER0];
    levelVec[SRC_SER1]      = prioB_q[PB_SER1];
    levelVec[SRC_ADC]       = prioB_q[PB_ADC];
  end

  assign hiReq = srcReq & levelVec;
  assign loReq = srcReq & ~levelVec;

  ipsel_pick #(.N(NSRC), .W(SRC_W)) uPickHi (
    .req  (hiReq),
    .found(hiFound),
    .idx  (hiIdx)
  );

  ipsel_pick #(.N(NSRC), .W(SRC_W)) uPickLo (
    .req  (loReq),
    .found(loFound),
    .idx  (loIdx)
  );

  // Maskable grant is withheld while the nonmaskable one waits
  always_comb begin
    intReq_d = '0;
    if (!nmiPending_q) begin
      if (hiFound) begin
        intReq_d = '{valid: 1'b1, level: 1'b1, source: hiIdx};
      end else if (loFound) begin
        intReq_d = '{valid: 1'b1, level: 1'b0, source: loIdx};
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      intReq_q <= '0;
    end else begin
      intReq_q <= intReq_d;
    end
  end
  assign intReq = intReq_q;

  nmi_fall_a: assert property (@(posedge clk) disable iff (!arst_n)
    (!sysCtrl_q[SC_NMI_EDGE] && nmiPrev_q && !nmiIn && !hwStandby)
    |=> nmiPending_q)
    else $error("falling edge did not raise nonmaskable request");

  nmi_rise_a: assert property (@(posedge clk) disable iff (!arst_n)
    (nmiPending_q == 1'b0 && !nmiEdge) |=> !nmiPending_q)
    else $error("nonmaskable request raised without selected edge");

  prio_write_a: assert property (@(posedge clk) disable iff (!arst_n)
    (wrStrobe && bus.address == ADR_PRIO_A && !hwStandby)
    |=> prioA_q == $past(bus.writedata[7:0]))
    else $error("register A did not take written byte");

  standby_a_a: assert property (@(posedge clk) disable iff (!arst_n)
    hwStandby |=> prioA_q == 8'h00)
    else $error("register A not cleared in standby");

  standby_b_a: assert property (@(posedge clk) disable iff (!arst_n)
    hwStandby |=> prioB_q == 8'h00)
    else $error("register B not cleared in standby");

  reserved_bits_a: assert property (@(posedge clk)
    disable iff (!arst_n)
    ($stable(prioA_q) && $stable(prioB_q & PB_LIVE_MASK))
    |-> $stable(levelVec))
    else $error("reserved bits changed a priority level");

  nmi_rank_a: assert property (@(posedge clk) disable iff (!arst_n)
    intReq_q.valid |-> !$past(nmiPending_q))
    else $error("maskable grant while nonmaskable pending");

  high_wins_a: assert property (@(posedge clk) disable iff (!arst_n)
    (|hiReq && !nmiPending_q) |=> (intReq_q.valid && intReq_q.level))
    else $error("high level request lost to low level");

  ext0_first_a: assert property (@(posedge clk) disable iff (!arst_n)
    (srcReq[SRC_EXT0] && prioA_q[PA_EXT0] && !nmiPending_q)
    |=> intReq_q.source == SRC_EXT0)
    else $error("fixed order not kept for external request 0");

  dma_pair_a: assert property (@(posedge clk) disable iff (!arst_n)
    (srcReq == NSRC'(1 << SRC_DMA1) && !nmiPending_q)
    |=> intReq_q.level == $past(prioB_q[PB_DMA]))
    else $error("DMA level does not follow its bit");

  bus_wait_a: assert property (@(posedge clk) disable iff (!arst_n)
    (bus.read && !ackQ_q) |-> waitrequest ##1 !waitrequest)
    else $error("read not answered on second cycle");

  nmi_rising_a: assert property (@(posedge clk) disable iff (!arst_n)
    (sysCtrl_q[SC_NMI_EDGE] && !nmiPrev_q && nmiIn && !hwStandby)
    |=> nmiPending_q)
    else $error("rising edge did not raise nonmaskable request");

  low_level_a: assert property (@(posedge clk) disable iff (!arst_n)
    (srcReq == NSRC'(1) && !prioA_q[PA_EXT0] && !nmiPending_q)
    |=> (intReq_q.valid && !intReq_q.level))
    else $error("level bit 0 did not give low level");

  // Mapping is checked through the arbiter, so a swapped bit shows up
  ext1_level_a: assert property (@(posedge clk) disable iff (!arst_n)
    (srcReq[SRC_EXT1] && prioA_q[PA_EXT1] && !nmiPending_q)
    |=> (intReq_q.valid && intReq_q.level))
    else $error("external request 1 not at high level");

  ext3_level_a: assert property (@(posedge clk) disable iff (!arst_n)
    (srcReq[SRC_EXT3] && prioA_q[PA_EXT2_3] && !nmiPending_q)
    |=> (intReq_q.valid && intReq_q.level))
    else $error("external request 3 not at high level");

  ext5_level_a: assert property (@(posedge clk) disable iff (!arst_n)
    (srcReq[SRC_EXT5] && prioA_q[PA_EXT4_5] && !nmiPending_q)
    |=> (intReq_q.valid && intReq_q.level))
    else $error("external request 5 not at high level");

  ref_level_a: assert property (@(posedge clk) disable iff (!arst_n)
    (srcReq[SRC_REF] && prioA_q[PA_WDT_REF] && !nmiPending_q)
    |=> (intReq_q.valid && intReq_q.level))
    else $error("refresh request not at high level");

  tmr0_level_a: assert property (@(posedge clk) disable iff (!arst_n)
    (srcReq[SRC_TMR0] && prioA_q[PA_TMR0] && !nmiPending_q)
    |=> (intReq_q.valid && intReq_q.level))
    else $error("timer channel 0 not at high level");

  tmr2_level_a: assert property (@(posedge clk) disable iff (!arst_n)
    (srcReq[SRC_TMR2] && prioA_q[PA_TMR2] && !nmiPending_q)
    |=> (intReq_q.valid && intReq_q.level))
    else $error("timer channel 2 not at high level");

  tmr4_level_a: assert property (@(posedge clk) disable iff (!arst_n)
    (srcReq[SRC_TMR4] && prioB_q[PB_TMR4] && !nmiPending_q)
    |=> (intReq_q.valid && intReq_q.level))
    else $error("timer channel 4 not at high level");

  dma0_level_a: assert property (@(posedge clk) disable iff (!arst_n)
    (srcReq[SRC_DMA0] && prioB_q[PB_DMA] && !nmiPending_q)
    |=> (intReq_q.valid && intReq_q.level))
    else $error("DMA channel 0 not at high level");

  ser1_level_a: assert property (@(posedge clk) disable iff (!arst_n)
    (srcReq[SRC_SER1] && prioB_q[PB_SER1] && !nmiPending_q)
    |=> (intReq_q.valid && intReq_q.level))
    else $error("serial channel 1 not at high level");

  adc_level_a: assert property (@(posedge clk) disable iff (!arst_n)
    (srcReq[SRC_ADC] && prioB_q[PB_ADC] && !nmiPending_q)
    |=> (intReq_q.valid && intReq_q.level))
    else $error("converter request not at high level");

  nmi_seen_c: cover property (@(posedge clk) disable iff (!arst_n)
    nmiEdge ##1 nmiPending_q);
  hi_grant_c: cover property (@(posedge clk) disable iff (!arst_n)
    intReq_q.valid && intReq_q.level);
  lo_grant_c: cover property (@(posedge clk) disable iff (!arst_n)
    intReq_q.valid && !intReq_q.level && |loReq);
  reg_write_c: cover property (@(posedge clk) disable iff (!arst_n)
    wrStrobe && bus.address == ADR_PRIO_B);
  nmi_ack_c: cover property (@(posedge clk) disable iff (!arst_n)
    nmiPending_q && nmiAck ##1 !nmiPending_q);

endmodule

// file: ipsel_cpu_model.sv
/*
  Behavioural CPU core on the far side of the priority selector.
  Assumes nmiPending and intReq are registered outputs on clk.
*/
`timescale 1ns/1ps
module ipsel_cpu_model (
  input  wire logic                 clk,
  input  wire logic                 arst_n,
  input  wire logic                 nmiPending,
  input  wire ipsel_pkg::ipsel_req_t intReq,
  input  wire logic [7:0]           ackDelay,
  output logic                      nmiAck
);
  import ipsel_pkg::*;
  logic [7:0] waitCnt;

  // Nonmaskable request is always taken, after a settable service delay
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      nmiAck  <= 1'b0;
      waitCnt <= 8'h00;
    end else if (nmiAck) begin
      nmiAck  <= 1'b0;
      waitCnt <= 8'h00;
    end else if (nmiPending) begin
      if (waitCnt == ackDelay) begin
        nmiAck <= 1'b1;
      end else begin
        waitCnt <= waitCnt + 8'h01;
      end
    end else begin
      waitCnt <= 8'h00;
    end
  end
endmodule

// file: tb_interrupt_priority_select.sv
/*
  Self-checking bench of the priority selector: register access over
  Avalon-MM, priority mapping, nonmaskable edge select and standby clear.
  Assumes the status word reflects nmiPending and the granted request.
*/
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
  check_count++; \
  if ((got) !== (ex)) begin \
    fail_count++; \
    $display("unexpected %s expected %h seen %h", nm, ex, got); \
  end
module tb_interrupt_priority_select;
  import ipsel_pkg::*;
  typedef struct { string nm; logic [31:0] v; } ipsel_note_t;
  logic              clk = 1'b0;
  logic              arst_n = 1'b0;
  logic              hwStandby = 1'b0;
  logic [ADDR_W-1:0] address = '0;
  logic              read = 1'b0;
  logic              write = 1'b0;
  logic [31:0]       writedata = 32'h0;
  logic [3:0]        byteenable = 4'h0;
  logic [31:0]       readdata;
  logic              waitrequest;
  logic              nmiIn = 1'b1;
  logic              nmiAck;
  logic [NSRC-1:0]   srcReq = '0;
  logic              nmiPending;
  ipsel_req_t        intReq;
  logic [7:0]        ackDelay = 8'h28;
  int                fail_count = 0;
  int                check_count = 0;
  logic [31:0]       seed = 32'h0000_0015;
  logic [31:0]       rnd;
  logic [15:0]       ab;
  logic [7:0]        exp;
  ipsel_note_t       notes[$];
  // Bit position in {A,B} that sets each source's level
  int pos[NSRC] = '{15, 14, 13, 13, 12, 12, 11, 11, 10, 9, 8, 7, 6, 5,
                    5, 3, 2, 1};

  always #4 clk = ~clk;

  ipsel_top ipsel_top_i (.clk(clk), .arst_n(arst_n), .hwStandby(hwStandby),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .nmiIn(nmiIn), .nmiAck(nmiAck),
    .srcReq(srcReq), .nmiPending(nmiPending), .intReq(intReq));
  ipsel_cpu_model ipsel_cpu_model_i (.clk(clk), .arst_n(arst_n),
    .nmiPending(nmiPending), .intReq(intReq), .ackDelay(ackDelay),
    .nmiAck(nmiAck));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  task automatic bus(input logic [ADDR_W-1:0] a, input logic wr,
                     input logic [7:0] d, input logic [3:0] be);
    address    <= a;
    read       <= !wr;
    write      <= wr;
    writedata  <= {24'h0, d};
    byteenable <= be;
    // Only the watchdog ends a wait that never gets an answer
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    read  <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    bus(a, 1'b1, d, 4'h1);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e,
                    input string nm);
    notes.push_back('{nm, {24'h0, e}});
    bus(a, 1'b0, 8'h00, 4'h1);
  endtask

  // Read data stand at the edge where waitrequest is seen low
  always @(posedge clk) begin
    if (read && waitrequest === 1'b0) begin
      if (notes.size() == 0) begin
        fail_count++;
        $display("unexpected readdata expected none seen %h", readdata);
      end else begin
        `CHK(notes[0].nm, notes[0].v, readdata)
        void'(notes.pop_front());
      end
    end
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    report_and_stop();
  end

  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rd(ADR_PRIO_A, RST_PRIO_A, "regA");
    rd(ADR_PRIO_B, RST_PRIO_B, "regB");
    rd(ADR_SYS_CTRL, 8'h00, "sysctrl");
    rd(ADR_STATUS, 8'h00, "status");
    rd(18'h00100, 8'h00, "unmapped");
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      rnd  = seed;
      wr(ADR_PRIO_A, rnd[7:0]);
      wr(ADR_PRIO_B, rnd[15:8]);
      rd(ADR_PRIO_A, rnd[7:0], "regA");
      rd(ADR_PRIO_B, rnd[15:8], "regB");
    end
    bus(ADR_PRIO_A, 1'b1, ~rnd[7:0], 4'h0);
    rd(ADR_PRIO_A, rnd[7:0], "regA");
    // Each source against a low competitor, its level bit clear then set
    for (int s = 0; s < NSRC; s++) begin
      for (int v = 0; v < 2; v++) begin
        ab = v ? (16'h1 << pos[s]) : 16'h0;
        wr(ADR_PRIO_A, ab[15:8]);
        wr(ADR_PRIO_B, ab[7:0]);
        srcReq <= (NSRC'(1) << s) |
                  (NSRC'(1) << ((s == 0) ? 1 : 0));
        repeat (2) @(posedge clk);
        exp = v ? {3'b011, 5'(s)} : 8'h40;
        rd(ADR_STATUS, exp, "grant");
      end
    end
    wr(ADR_PRIO_B, 8'h20);
    srcReq <= NSRC'(1) << SRC_DMA1;
    repeat (2) @(posedge clk);
    rd(ADR_STATUS, {3'b011, 5'(SRC_DMA1)}, "dmaAlone");
    // Reserved bits must not raise the converter above source 0
    wr(ADR_PRIO_A, 8'h00);
    wr(ADR_PRIO_B, 8'h11);
    srcReq <= NSRC'(1) | (NSRC'(1) << SRC_ADC);
    repeat (2) @(posedge clk);
    rd(ADR_STATUS, 8'h40, "reserved");
    srcReq <= NSRC'(1);
    nmiIn  <= 1'b0;
    repeat (2) @(posedge clk);
    rd(ADR_STATUS, 8'h80, "nmiFall");
    repeat (60) @(posedge clk);
    rd(ADR_STATUS, 8'h40, "nmiAcked");
    nmiIn <= 1'b1;
    repeat (2) @(posedge clk);
    rd(ADR_STATUS, 8'h40, "nmiRiseSel0");
    wr(ADR_SYS_CTRL, 8'h04);
    rd(ADR_SYS_CTRL, 8'h04, "sysctrl");
    nmiIn <= 1'b0;
    repeat (2) @(posedge clk);
    rd(ADR_STATUS, 8'h40, "nmiFallSel1");
    nmiIn <= 1'b1;
    repeat (2) @(posedge clk);
    rd(ADR_STATUS, 8'h80, "nmiRiseSel1");
    repeat (60) @(posedge clk);
    srcReq <= '0;
    wr(ADR_PRIO_A, 8'h5a);
    wr(ADR_PRIO_B, 8'ha5);
    hwStandby <= 1'b1;
    repeat (2) @(posedge clk);
    hwStandby <= 1'b0;
    @(posedge clk);
    rd(ADR_PRIO_A, 8'h00, "regA");
    rd(ADR_PRIO_B, 8'h00, "regB");
    rd(ADR_SYS_CTRL, 8'h00, "sysctrl");
    repeat (2) @(posedge clk);
    report_and_stop();
  end
endmodule
